//--- verilog/htr_pkg.sv
// shared constants for the humidity and temperature readout link
package htr_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_HZ = 125_000_000;
    localparam int POWERUP_MS = 10;
    localparam int MEAS_MS = 60;
    localparam int POWERUP_CYC = CLK_HZ / 1000 * POWERUP_MS;
    localparam int MEAS_CYC = CLK_HZ / 1000 * MEAS_MS;
    localparam int BIT_RATE_MIN = 100_000;
    localparam int BIT_RATE_MAX = 400_000;
    // ==========================================================
    // link encodings
    localparam logic [6:0] TARGET_ADDR = 7'h10;
    localparam logic DIR_UPDATE = 1'h0;
    localparam logic DIR_READ = 1'h1;
    localparam logic [1:0] STAT_FRESH = 2'h0;
    localparam logic [1:0] STAT_STALE = 2'h1;
    localparam logic [1:0] LAST_BYTE = 2'h3;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam int HUM_HI_POS = 8;
    localparam int TEMP_LO_POS = 6;
endpackage

//--- verilog/htr_link_if.sv
// two-wire link between the sensor end and the master end
`timescale 1ns/1ps
interface htr_link_if;
    logic host_scl_out;
    logic host_scl_oe;
    logic host_sda_out;
    logic host_sda_oe;
    logic dev_sda_out;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // ==========================================================
    // open-drain wires with pull-ups
    assign scl = ~(host_scl_oe & ~host_scl_out);
    assign sda = ~(host_sda_oe & ~host_sda_out) & ~(dev_sda_oe & ~dev_sda_out);

    modport host (
        output host_scl_out,
        output host_scl_oe,
        output host_sda_out,
        output host_sda_oe,
        input scl,
        input sda
    );
    modport dev (
        output dev_sda_out,
        output dev_sda_oe,
        input scl,
        input sda
    );
endinterface

//--- verilog/htr_line_sync.sv
// two-flop synchroniser with edge detection for one link line
`timescale 1ns/1ps
module htr_line_sync
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // line
    input wire logic line_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= 1'h1;
            sync_reg <= 1'h1;
            last_reg <= 1'h1;
        end
        else
        begin
            meta_reg <= line_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise = sync_reg & ~last_reg;
    assign fall = ~sync_reg & last_reg;
endmodule

//--- verilog/htr_sensor.sv
// sensor end: power-up wait, sleep, measurement and byte readout
// Function
// - wait 10 ms after power-up, ignore commands
// - master sends nothing before settling ends
// - start, then update or read command byte
// - sleep until a valid update command
// - update runs a 60 ms measurement
// - load results into output registers at end
// - update byte is address 10h, direction 0
// - acknowledge the command byte with low bit
// - read byte is address 10h, direction 1
// - send humidity high, low, temperature high, low
// - master acks each byte; missing ack stops
// - master reads only after measurement completes; htr_master has no such wait and reads on any cmd_read in M_IDLE
// - humidity high top bits: 00 fresh, 01 read
// - humidity is 14 bits, six plus eight
// - temperature is 14 bits, eight plus six
// - master ignores temperature low two bits
// - link runs from 100 to 400 kbit/s
`timescale 1ns/1ps
module htr_sensor
    import htr_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_CYC,
    parameter int MEAS_CYCLES = MEAS_CYC
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // link
    htr_link_if.dev link,
    // measurement side
    input wire logic [13:0] hum_result,
    input wire logic [13:0] temp_result,
    output logic meas_start,
    output logic meas_busy,
    output logic awake
);
    localparam int TW = $clog2(MEAS_CYCLES + POWERUP_CYCLES + 1);

    if (POWERUP_CYCLES < 1 || MEAS_CYCLES < 1)
        $error("htr_sensor: cycle counts must be positive");

    typedef enum logic [1:0] {
        LIFE_PWRUP = 2'h0,
        LIFE_SLEEP = 2'h1,
        LIFE_MEAS = 2'h2
    } htr_life_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'h0,
        BUS_ADDR = 3'h1,
        BUS_ACK = 3'h2,
        BUS_TX = 3'h3,
        BUS_RXACK = 3'h4,
        BUS_SKIP = 3'h5
    } htr_bus_t;

    htr_life_t life_reg;
    htr_bus_t bus_reg;
    logic [TW-1:0] tmr_reg;
    logic [13:0] hum_reg;
    logic [13:0] temp_reg;
    logic [1:0] status_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_reg;
    logic [1:0] idx_reg;
    logic rd_reg;
    logic got_ack_reg;
    logic scl_lvl;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic sda_rise;
    logic sda_fall;
    logic bus_start;
    logic bus_stop;
    logic update_cmd;
    logic readout_done;
    logic meas_end;

    // ==========================================================
    // line sampling
    htr_line_sync u_scl_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .line_in(link.scl),
        .level(scl_lvl),
        .rise(scl_rise),
        .fall(scl_fall)
    );

    htr_line_sync u_sda_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .line_in(link.sda),
        .level(sda_lvl),
        .rise(sda_rise),
        .fall(sda_fall)
    );

    assign bus_start = sda_fall & scl_lvl;
    assign bus_stop = sda_rise & scl_lvl;

    // outgoing byte by position in the readout
    function automatic logic [7:0] byte_sel(input logic [1:0] idx);
        unique case (idx)
            2'h0: byte_sel = {status_reg, hum_reg[13:HUM_HI_POS]};
            2'h1: byte_sel = hum_reg[HUM_HI_POS-1:0];
            2'h2: byte_sel = temp_reg[13:TEMP_LO_POS];
            2'h3: byte_sel = {temp_reg[TEMP_LO_POS-1:0], 2'h0};
        endcase
    endfunction

    // ==========================================================
    // power-up, sleep and measurement
    assign meas_end = life_reg == LIFE_MEAS && tmr_reg == TW'(MEAS_CYCLES - 1);

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            life_reg <= LIFE_PWRUP;
            tmr_reg <= '0;
        end
        else
        begin
            unique case (life_reg)
                LIFE_PWRUP:
                begin
                    if (tmr_reg == TW'(POWERUP_CYCLES - 1))
                    begin
                        life_reg <= LIFE_SLEEP;
                        tmr_reg <= '0;
                    end
                    else
                        tmr_reg <= tmr_reg + 1'b1;
                end
                LIFE_SLEEP:
                begin
                    if (update_cmd)
                    begin
                        life_reg <= LIFE_MEAS;
                        tmr_reg <= '0;
                    end
                end
                LIFE_MEAS:
                begin
                    if (meas_end)
                    begin
                        life_reg <= LIFE_SLEEP;
                        tmr_reg <= '0;
                    end
                    else
                        tmr_reg <= tmr_reg + 1'b1;
                end
                default:
                    life_reg <= LIFE_PWRUP;
            endcase
        end
    end

    assign awake = life_reg != LIFE_PWRUP;
    assign meas_busy = life_reg == LIFE_MEAS;
    assign meas_start = life_reg == LIFE_SLEEP && update_cmd;

    // ==========================================================
    // output registers and data status
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            hum_reg <= '0;
            temp_reg <= '0;
            status_reg <= STAT_STALE;
        end
        else if (meas_end)
        begin
            hum_reg <= hum_result;
            temp_reg <= temp_result;
            status_reg <= STAT_FRESH;
        end
        else if (readout_done)
            status_reg <= STAT_STALE;
    end

    // ==========================================================
    // target byte engine
    assign update_cmd = bus_reg == BUS_ACK && scl_fall && rd_reg == DIR_UPDATE;
    assign readout_done = bus_reg == BUS_RXACK && scl_fall && got_ack_reg
        && idx_reg == LAST_BYTE;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            bus_reg <= BUS_IDLE;
            shift_reg <= '0;
            bit_reg <= '0;
            idx_reg <= '0;
            rd_reg <= 1'h0;
            got_ack_reg <= 1'h0;
        end
        else if (bus_start)
        begin
            bus_reg <= BUS_ADDR;
            bit_reg <= '0;
        end
        else if (bus_stop)
            bus_reg <= BUS_IDLE;
        else
        begin
            unique case (bus_reg)
                BUS_IDLE, BUS_SKIP:
                    bus_reg <= bus_reg;
                BUS_ADDR:
                begin
                    if (scl_rise)
                    begin
                        shift_reg <= {shift_reg[6:0], sda_lvl};
                        bit_reg <= bit_reg + 1'b1;
                    end
                    else if (scl_fall && bit_reg == ACK_SLOT)
                    begin
                        rd_reg <= shift_reg[0];
                        if (shift_reg[7:1] == TARGET_ADDR && awake)
                            bus_reg <= BUS_ACK;
                        else
                            bus_reg <= BUS_SKIP;
                    end
                end
                BUS_ACK:
                begin
                    if (scl_fall && rd_reg == DIR_READ)
                    begin
                        bus_reg <= BUS_TX;
                        shift_reg <= byte_sel(2'h0);
                        idx_reg <= '0;
                        bit_reg <= '0;
                    end
                    else if (scl_fall)
                        bus_reg <= BUS_SKIP;
                end
                BUS_TX:
                begin
                    if (scl_fall && bit_reg == LAST_BIT)
                        bus_reg <= BUS_RXACK;
                    else if (scl_fall)
                    begin
                        shift_reg <= {shift_reg[6:0], 1'h0};
                        bit_reg <= bit_reg + 1'b1;
                    end
                end
                BUS_RXACK:
                begin
                    if (scl_rise)
                        got_ack_reg <= ~sda_lvl;
                    else if (scl_fall && got_ack_reg && idx_reg != LAST_BYTE)
                    begin
                        bus_reg <= BUS_TX;
                        idx_reg <= idx_reg + 1'b1;
                        shift_reg <= byte_sel(idx_reg + 1'b1);
                        bit_reg <= '0;
                    end
                    else if (scl_fall)
                        bus_reg <= BUS_SKIP;
                end
                default:
                    bus_reg <= BUS_IDLE;
            endcase
        end
    end

    // ==========================================================
    // open-drain data drive
    assign link.dev_sda_out = 1'h0;
    assign link.dev_sda_oe = bus_reg == BUS_ACK
        || (bus_reg == BUS_TX && !shift_reg[7]);
endmodule

//--- verilog/htr_master.sv
// master end: issues update and read commands and collects results
`timescale 1ns/1ps
module htr_master
    import htr_pkg::*;
#(
    parameter int BIT_RATE = BIT_RATE_MIN,
    parameter int POWERUP_CYCLES = POWERUP_CYC
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // link
    htr_link_if.host link,
    // command side
    input wire logic cmd_update,
    input wire logic cmd_read,
    output logic ready,
    // result side
    output logic [1:0] status,
    output logic [13:0] humidity,
    output logic [13:0] temperature,
    output logic result_valid,
    output logic nack_seen
);
    localparam int QUARTER = CLK_HZ / (4 * BIT_RATE);
    localparam int DW = $clog2(QUARTER + 1);
    localparam int SW = $clog2(POWERUP_CYCLES + 1);

    if (BIT_RATE < BIT_RATE_MIN || BIT_RATE > BIT_RATE_MAX)
        $error("htr_master: bit rate out of range");
    if (POWERUP_CYCLES < 1)
        $error("htr_master: settle count must be positive");

    typedef enum logic [2:0] {
        M_SETTLE = 3'h0,
        M_IDLE = 3'h1,
        M_START = 3'h2,
        M_ADDR = 3'h3,
        M_DATA = 3'h4,
        M_STOP = 3'h5
    } htr_mst_t;

    htr_mst_t st_reg;
    logic [SW-1:0] settle_reg;
    logic [DW-1:0] div_reg;
    logic [1:0] q_reg;
    logic [3:0] slot_reg;
    logic [1:0] idx_reg;
    logic [7:0] shift_reg;
    logic rd_reg;
    logic smp_reg;
    logic [7:0] b0_reg;
    logic [7:0] b1_reg;
    logic [7:0] b2_reg;
    logic sda_lvl;
    logic tick;
    logic slot_end;

    htr_line_sync u_sda_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .line_in(link.sda),
        .level(sda_lvl),
        .rise(),
        .fall()
    );

    // ==========================================================
    // quarter-bit divider
    assign tick = div_reg == DW'(QUARTER - 1);
    assign slot_end = tick && q_reg == 2'h3;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            div_reg <= '0;
            q_reg <= '0;
        end
        else if (st_reg == M_IDLE || st_reg == M_SETTLE || tick)
        begin
            div_reg <= '0;
            q_reg <= (st_reg == M_IDLE || st_reg == M_SETTLE) ? 2'h0
                : q_reg + 1'b1;
        end
        else
            div_reg <= div_reg + 1'b1;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            smp_reg <= 1'h1;
        else if (tick && q_reg == 2'h2)
            smp_reg <= sda_lvl;
    end

    // ==========================================================
    // command sequencer
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= M_SETTLE;
            settle_reg <= '0;
            slot_reg <= '0;
            idx_reg <= '0;
            shift_reg <= '0;
            rd_reg <= 1'h0;
            nack_seen <= 1'h0;
            result_valid <= 1'h0;
            b0_reg <= '0;
            b1_reg <= '0;
            b2_reg <= '0;
            status <= '0;
            humidity <= '0;
            temperature <= '0;
        end
        else
        begin
            result_valid <= 1'h0;
            unique case (st_reg)
                M_SETTLE:
                begin
                    if (settle_reg == SW'(POWERUP_CYCLES - 1))
                        st_reg <= M_IDLE;
                    else
                        settle_reg <= settle_reg + 1'b1;
                end
                M_IDLE:
                begin
                    if (cmd_update || cmd_read)
                    begin
                        st_reg <= M_START;
                        rd_reg <= cmd_read;
                        shift_reg <= {TARGET_ADDR,
                            cmd_read ? DIR_READ : DIR_UPDATE};
                        nack_seen <= 1'h0;
                    end
                end
                M_START:
                begin
                    if (slot_end)
                    begin
                        st_reg <= M_ADDR;
                        slot_reg <= '0;
                    end
                end
                M_ADDR:
                begin
                    if (slot_end && slot_reg != ACK_SLOT)
                    begin
                        shift_reg <= {shift_reg[6:0], 1'h0};
                        slot_reg <= slot_reg + 1'b1;
                    end
                    else if (slot_end)
                    begin
                        nack_seen <= smp_reg;
                        slot_reg <= '0;
                        idx_reg <= '0;
                        st_reg <= (!smp_reg && rd_reg) ? M_DATA : M_STOP;
                    end
                end
                M_DATA:
                begin
                    if (slot_end && slot_reg != ACK_SLOT)
                    begin
                        shift_reg <= {shift_reg[6:0], smp_reg};
                        slot_reg <= slot_reg + 1'b1;
                    end
                    else if (slot_end)
                    begin
                        slot_reg <= '0;
                        idx_reg <= idx_reg + 1'b1;
                        unique case (idx_reg)
                            2'h0: b0_reg <= shift_reg;
                            2'h1: b1_reg <= shift_reg;
                            2'h2: b2_reg <= shift_reg;
                            2'h3:
                            begin
                                status <= b0_reg[7:6];
                                humidity <= {b0_reg[5:0], b1_reg};
                                temperature <= {b2_reg,
                                    shift_reg[7:2]};
                                result_valid <= 1'h1;
                                st_reg <= M_STOP;
                            end
                        endcase
                    end
                end
                M_STOP:
                begin
                    if (slot_end)
                        st_reg <= M_IDLE;
                end
                default:
                    st_reg <= M_SETTLE;
            endcase
        end
    end

    assign ready = st_reg == M_IDLE;

    // ==========================================================
    // open-drain clock and data drive
    assign link.host_scl_out = 1'h0;
    assign link.host_sda_out = 1'h0;
    always_comb
    begin
        link.host_scl_oe = 1'h0;
        link.host_sda_oe = 1'h0;
        unique case (st_reg)
            M_START:
            begin
                link.host_scl_oe = q_reg == 2'h3;
                link.host_sda_oe = q_reg[1];
            end
            M_ADDR:
            begin
                link.host_scl_oe = q_reg == 2'h0 || q_reg == 2'h3;
                link.host_sda_oe = slot_reg != ACK_SLOT && !shift_reg[7];
            end
            M_DATA:
            begin
                link.host_scl_oe = q_reg == 2'h0 || q_reg == 2'h3;
                link.host_sda_oe = slot_reg == ACK_SLOT;
            end
            M_STOP:
            begin
                link.host_scl_oe = q_reg == 2'h0;
                link.host_sda_oe = q_reg != 2'h3;
            end
            M_SETTLE, M_IDLE:
            begin
                link.host_scl_oe = 1'h0;
                link.host_sda_oe = 1'h0;
            end
            default:
            begin
                link.host_scl_oe = 1'h0;
                link.host_sda_oe = 1'h0;
            end
        endcase
    end
endmodule

//--- bench/htr_link_checker.sv
// assertions on the sensor end of the first link
`timescale 1ns/1ps
module htr_link_checker
#(
    parameter int MEAS_CYCLES = 500
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // link
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe,
    input wire logic scl,
    // sensor state
    input wire logic awake,
    input wire logic meas_start,
    input wire logic meas_busy
);
    logic [31:0] busy_reg;
    logic [15:0] rise_reg;
    // ====================
    // helper counters
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            busy_reg <= '0;
        else
            busy_reg <= meas_busy ? busy_reg + 32'h1 : 32'h0;
    end
    // cycles since last clock rise, saturating
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            rise_reg <= 16'hffff;
        else if ($rose(scl))
            rise_reg <= 16'h0;
        else if (rise_reg != 16'hffff)
            rise_reg <= rise_reg + 16'h1;
    end
    // ====================
    // properties
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    property p_quiet_asleep;
        !awake |-> !dev_sda_oe;
    endproperty
    a_quiet_asleep: assert property (p_quiet_asleep)
        else $error("line pulled before wake");
    property p_stay_awake;
        awake |=> awake;
    endproperty
    a_stay_awake: assert property (p_stay_awake)
        else $error("awake dropped");
    property p_meas_follow;
        meas_start |=> meas_busy [*8];
    endproperty
    a_meas_follow: assert property (p_meas_follow)
        else $error("start without busy");
    property p_meas_len;
        $fell(meas_busy) |-> busy_reg >= MEAS_CYCLES
            && busy_reg <= MEAS_CYCLES + 1;
    endproperty
    a_meas_len: assert property (p_meas_len)
        else $error("measurement length wrong");
    property p_no_restart;
        meas_busy && $past(meas_busy) |-> !meas_start;
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("restart while busy");
    property p_ack_low;
        dev_sda_oe |-> !dev_sda_out;
    endproperty
    a_ack_low: assert property (p_ack_low)
        else $error("sensor drove line high");
    property p_drive_on_low;
        $rose(dev_sda_oe) |-> !scl;
    endproperty
    a_drive_on_low: assert property (p_drive_on_low)
        else $error("data changed with clock high");
    property p_bit_rate;
        $rose(scl) |-> rise_reg >= 16'h136;
    endproperty
    a_bit_rate: assert property (p_bit_rate)
        else $error("link clock too fast");
    c_start: cover property (meas_start);
    c_ack: cover property ($rose(dev_sda_oe));
    c_done: cover property ($fell(meas_busy));
endmodule

//--- bench/humidity_temp_i2c_readout_tb.sv
// bench for the sensor and master ends of the readout link
`timescale 1ns/1ps
module humidity_temp_i2c_readout_tb
    import htr_pkg::*;
;
    typedef struct packed {
        logic upd;
        logic [13:0] hum;
        logic [13:0] temp;
        logic [1:0] stat;
    } htr_row_t;
    localparam int PU = 200;
    localparam int MC = 500;
    localparam int QB = 5;
    localparam logic [13:0] H2 = 14'h1234;
    localparam logic [13:0] T2 = 14'h0abd;
    htr_row_t rows [3] = '{'{1'h1, 14'h3fff, 14'h0000, STAT_FRESH},
        '{1'h0, 14'h3fff, 14'h0000, STAT_STALE},
        '{1'h1, 14'h2a5c, 14'h15a3, STAT_FRESH}};
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic cmd_update = 1'h0;
    logic cmd_read = 1'h0;
    logic [13:0] hum_result = 14'h0;
    logic [13:0] temp_result = 14'h0;
    logic ready, nack_seen, meas_start, meas_busy, awake, busy_b, s, result_valid;
    logic [1:0] status;
    logic [13:0] humidity, temperature;
    logic [7:0] rx;
    int n;
    int errors = 0;
    int samples_checked = 0;
    int valid_cnt = 0;

    htr_link_if link();
    htr_link_if link_b();
    htr_sensor #(.POWERUP_CYCLES(PU), .MEAS_CYCLES(MC)) u_htr_sensor (
        .clk_sys(clk_sys), .rst(rst), .link(link.dev),
        .hum_result(hum_result), .temp_result(temp_result),
        .meas_start(meas_start), .meas_busy(meas_busy), .awake(awake));
    // second sensor faces the bench-driven link
    htr_sensor #(.POWERUP_CYCLES(PU), .MEAS_CYCLES(MC)) u_htr_sensor_b (
        .clk_sys(clk_sys), .rst(rst), .link(link_b.dev),
        .hum_result(hum_result), .temp_result(temp_result),
        .meas_start(), .meas_busy(busy_b), .awake());
    htr_master #(.BIT_RATE(BIT_RATE_MAX), .POWERUP_CYCLES(PU)) u_htr_master (
        .clk_sys(clk_sys), .rst(rst), .link(link.host),
        .cmd_update(cmd_update), .cmd_read(cmd_read), .ready(ready),
        .status(status), .humidity(humidity), .temperature(temperature),
        .result_valid(result_valid), .nack_seen(nack_seen));
    htr_link_checker #(.MEAS_CYCLES(MC)) u_htr_link_checker (
        .clk_sys(clk_sys), .rst(rst), .dev_sda_out(link.dev_sda_out),
        .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .awake(awake),
        .meas_start(meas_start), .meas_busy(meas_busy));

    always #4 clk_sys = ~clk_sys;

    always @(negedge clk_sys)
        if (result_valid === 1'h1)
            valid_cnt++;

    // ====================
    // tasks
    task automatic chk(input string what, input logic [15:0] exp, got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wait_ready(input logic v);
        n = 0;
        while (ready !== v && n < 20000)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk("ready", 16'(v), 16'(ready));
    endtask
    task automatic master_op(input logic rd);
        wait_ready(1'h1);
        cmd_read = rd;
        cmd_update = ~rd;
        @(negedge clk_sys);
        cmd_read = 1'h0;
        cmd_update = 1'h0;
        wait_ready(1'h0);
        wait_ready(1'h1);
    endtask
    // bench as master on the second link
    task automatic bb_set(input logic scl_oe, sda_oe);
        link_b.host_scl_oe = scl_oe;
        link_b.host_sda_oe = sda_oe;
        repeat (QB) @(negedge clk_sys);
    endtask
    task automatic bb_bit(input logic b, output logic bit_in);
        bb_set(1'h1, ~b);
        bb_set(1'h0, ~b);
        bit_in = link_b.sda;
    endtask
    task automatic bb_byte(input logic [7:0] tx);
        for (int i = 7; i >= 0; i--)
            bb_bit(tx[i], rx[i]);
    endtask
    task automatic bb_cmd(input logic [7:0] c);
        bb_set(1'h0, 1'h1);
        bb_set(1'h1, 1'h1);
        bb_byte(c);
        bb_bit(1'h1, s);
    endtask
    task automatic bb_stop();
        bb_set(1'h1, 1'h1);
        bb_set(1'h0, 1'h1);
        bb_set(1'h0, 1'h0);
    endtask
    task automatic bb_read(input int cnt, input logic [1:0] st);
        logic [7:0] ex [4];
        ex = '{{st, H2[13:8]}, H2[7:0], T2[13:6], {T2[5:0], 2'h0}};
        bb_cmd({TARGET_ADDR, DIR_READ});
        chk("read ack", 16'h0, 16'(s));
        for (int i = 0; i < cnt; i++)
        begin
            bb_byte(8'hff);
            bb_bit(i == cnt - 1 && cnt < 4, s);
            rx[1:0] = (i == 3) ? 2'h0 : rx[1:0];
            chk("byte", {8'h0, ex[i]}, {8'h0, rx});
        end
        if (cnt < 4)
        begin
            bb_byte(8'hff);
            chk("after nack", 16'hff, {8'h0, rx});
        end
        bb_stop();
    endtask

    // ====================
    // sequence
    initial
    begin
        link_b.host_scl_out = 1'h0;
        link_b.host_sda_out = 1'h0;
        link_b.host_scl_oe = 1'h0;
        link_b.host_sda_oe = 1'h0;
        repeat (20) @(negedge clk_sys);
        rst = 1'h0;
        n = 0;
        while (awake !== 1'h1 && n < 1000)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk("wake delay", 16'h1, 16'(n >= PU && n <= PU + 1));
        for (int r = 0; r < 3; r++)
        begin
            if (rows[r].upd)
            begin
                hum_result = rows[r].hum;
                temp_result = rows[r].temp;
                master_op(1'h0);
                chk("update nack", 16'h0, 16'(nack_seen));
                repeat (MC + 20) @(negedge clk_sys);
                chk("busy", 16'h0, 16'(meas_busy));
                hum_result = ~rows[r].hum;
                temp_result = ~rows[r].temp;
            end
            master_op(1'h1);
            chk("status", 16'(rows[r].stat), 16'(status));
            chk("humidity", 16'(rows[r].hum), 16'(humidity));
            chk("temp", 16'(rows[r].temp), 16'(temperature));
        end
        chk("valid pulses", 16'($size(rows)), 16'(valid_cnt));
        // awkward cases on the bench-driven link
        hum_result = H2;
        temp_result = T2;
        bb_cmd(8'h22);
        bb_stop();
        chk("foreign ack", 16'h1, 16'(s));
        chk("foreign busy", 16'h0, 16'(busy_b));
        bb_cmd({TARGET_ADDR, DIR_UPDATE});
        bb_stop();
        chk("update ack", 16'h0, 16'(s));
        chk("measuring", 16'h1, 16'(busy_b));
        bb_cmd({TARGET_ADDR, DIR_UPDATE});
        bb_stop();
        chk("busy ack", 16'h0, 16'(s));
        repeat (MC - 100) @(negedge clk_sys);
        chk("measured", 16'h0, 16'(busy_b));
        bb_read(2, STAT_FRESH);
        bb_read(4, STAT_FRESH);
        bb_read(1, STAT_STALE);
        conclude();
    end

    initial
    begin
        #600000;
        errors++;
        conclude();
    end
endmodule
